// [common/bpt_map.vh]
`ifndef BPT_MAP_VH
`define BPT_MAP_VH

// register addresses (7-bit address field of the serial frame)
`define BPT_ADDR_CONFIG_DONE   7'h00
`define BPT_ADDR_GATE_EN       7'h01
`define BPT_ADDR_GATE_OUT      7'h02
`define BPT_ADDR_LOOP_DIV      7'h09
`define BPT_ADDR_OUT1_PH_EN    7'h0B
`define BPT_ADDR_OUT2_PH_EN    7'h0C
`define BPT_ADDR_OFF_DELAY     7'h0D
`define BPT_ADDR_GATE_PHASE    7'h0F
`define BPT_ADDR_ROUTING       7'h10
`define BPT_ADDR_STATUS        7'h1E

// field positions
`define BPT_DELAY_MSB          7
`define BPT_DELAY_LSB          3
`define BPT_OFF_MSB            2
`define BPT_OFF_LSB            0
`define BPT_PH_EN_MSB          3
`define BPT_ROUTE_MSB          1

// reset values
`define BPT_RST_BYTE           8'h00
`define BPT_RST_NIBBLE         4'h0
`define BPT_RST_ROUTE          2'h0

// serial frame layout
`define BPT_FRAME_BITS         5'h10
`define BPT_HDR_BITS           5'h08

// timing: shortest phase-off time in divided periods
`define BPT_MIN_OFF            3'h1

`endif

// [hw/bpt_spi_slave.v]
`timescale 1ns/1ns
`default_nettype none
`include "bpt_map.vh"

module bpt_spi_slave (
  // clock and reset
  input  wire       clk,
  input  wire       rstn,
  // serial pins
  input  wire       sclk_pin,
  input  wire       csb_n_pin,
  input  wire       sdi_pin,
  output reg        sdo_r,
  // register side
  output reg  [6:0] addr_r,
  output reg  [7:0] wdata_r,
  output reg        wr_stb_r,
  input  wire [7:0] rdata
);

  // ********************************
  // pin synchronisers
  // ********************************
  reg  [1:0] sclk_s_r;
  reg  [1:0] csb_s_r;
  reg  [1:0] sdi_s_r;
  reg        sclk_d_r;
  reg  [4:0] bit_cnt_r;
  reg [15:0] rx_r;
  reg  [7:0] tx_r;
  reg        load_r;
  wire       rise;
  wire       fall;
  wire       sel;

  assign sel  = ~csb_s_r[1];
  assign rise = sclk_s_r[1] & ~sclk_d_r;
  assign fall = ~sclk_s_r[1] & sclk_d_r;

  always @(posedge clk) begin
    if (!rstn) begin
      sclk_s_r <= 2'h0;
      csb_s_r  <= 2'h3;
      sdi_s_r  <= 2'h0;
      sclk_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], sclk_pin};
      csb_s_r  <= {csb_s_r[0], csb_n_pin};
      sdi_s_r  <= {sdi_s_r[0], sdi_pin};
      sclk_d_r <= sclk_s_r[1];
    end
  end

  // ********************************
  // frame engine
  // ********************************
  // mode 0, msb first: write flag, 7 address bits, 8 data bits
  always @(posedge clk) begin
    if (!rstn) begin
      bit_cnt_r <= 5'h00;
      rx_r      <= 16'h0000;
      tx_r      <= 8'h00;
      load_r    <= 1'b0;
      sdo_r     <= 1'b0;
      addr_r    <= 7'h00;
      wdata_r   <= 8'h00;
      wr_stb_r  <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      load_r   <= 1'b0;
      if (!sel) begin
        // a frame cut short by the select is dropped whole
        bit_cnt_r <= 5'h00;
        sdo_r     <= 1'b0;
      end else begin
        if (rise) begin
          rx_r      <= {rx_r[14:0], sdi_s_r[1]};
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (bit_cnt_r == `BPT_HDR_BITS - 5'h01) begin
            addr_r <= {rx_r[5:0], sdi_s_r[1]};
            load_r <= 1'b1;
          end
          if (bit_cnt_r == `BPT_FRAME_BITS - 5'h01) begin
            wdata_r  <= {rx_r[6:0], sdi_s_r[1]};
            wr_stb_r <= rx_r[14];
          end
        end
        if (load_r) begin
          tx_r <= rdata;
        end else if (fall && bit_cnt_r >= `BPT_HDR_BITS) begin
          sdo_r <= tx_r[7];
          tx_r  <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

endmodule
`default_nettype wire

// [hw/bpt_config_top.v]
// What this block does
// - up to four phases on each of two outputs
// - output 1 enable bits 3:0 pick phases
// - output 2 enables share the same layout
// - routing field picks internal phase for gate
// - gate enable bit switches physical phase
// - loop clock is oscillator over divider+1
// - divided clock times off-time and delay
// - inter-phase delay is field plus one periods
// - off-time is field periods, zero gives one
// - phase count and delay set switching period
// - fixed frequency, every phase slot regular
// - config registers locked once done is set
// - clearing done reopens config writes
`timescale 1ns/1ns
`default_nettype none
`include "bpt_map.vh"

module bpt_config_top (
  // clock and reset
  input  wire       CORE_CLK,
  input  wire       RSTN,
  // serial port
  input  wire       SCLK,
  input  wire       CSB_N,
  input  wire       SDI,
  output wire       SDO,
  // converter side
  output reg        PHYSICAL_GATE_ON,
  output reg  [3:0] OUT1_PHASES,
  output reg  [3:0] OUT2_PHASES,
  output reg        OPERATION_MODE
);

  // ********************************
  // register storage
  // ********************************
  reg        config_done_flag_r;
  reg        physical_gate_on_r;
  reg        gate_output_select_r;
  reg  [7:0] loop_divider_value_r;
  reg  [3:0] out1_phase_en_r;
  reg  [3:0] out2_phase_en_r;
  reg  [4:0] inter_phase_delay_r;
  reg  [2:0] phase_off_time_r;
  reg        gate_phase_output_select_r;
  reg  [1:0] internal_phase_route_r;

  wire [6:0] addr;
  wire [7:0] wdata;
  wire       wr_stb;
  wire [7:0] rdata;
  wire [7:0] ph_all;

  bpt_spi_slave u_spi (
    .clk       (CORE_CLK),
    .rstn      (RSTN),
    .sclk_pin  (SCLK),
    .csb_n_pin (CSB_N),
    .sdi_pin   (SDI),
    .sdo_r     (SDO),
    .addr_r    (addr),
    .wdata_r   (wdata),
    .wr_stb_r  (wr_stb),
    .rdata     (rdata)
  );

  // status byte: done, gate, two zero bits, output 1 phases
  function [7:0] rd_mux;
    input [6:0] a;
    begin
      case (a)
        `BPT_ADDR_CONFIG_DONE: rd_mux = {7'h00, config_done_flag_r};
        `BPT_ADDR_GATE_EN:     rd_mux = {7'h00, physical_gate_on_r};
        `BPT_ADDR_GATE_OUT:    rd_mux = {7'h00, gate_output_select_r};
        `BPT_ADDR_LOOP_DIV:    rd_mux = loop_divider_value_r;
        `BPT_ADDR_OUT1_PH_EN:  rd_mux = {4'h0, out1_phase_en_r};
        `BPT_ADDR_OUT2_PH_EN:  rd_mux = {4'h0, out2_phase_en_r};
        `BPT_ADDR_OFF_DELAY:   rd_mux = {inter_phase_delay_r, phase_off_time_r};
        `BPT_ADDR_GATE_PHASE:  rd_mux = {7'h00, gate_phase_output_select_r};
        `BPT_ADDR_ROUTING:     rd_mux = {6'h00, internal_phase_route_r};
        `BPT_ADDR_STATUS:      rd_mux = {config_done_flag_r, PHYSICAL_GATE_ON, 2'h0,
                                         ph_all[3:0]};
        default:               rd_mux = `BPT_RST_BYTE;
      endcase
    end
  endfunction

  assign rdata = rd_mux(addr);

  // ********************************
  // register writes
  // ********************************
  // the done flag stays writable in every mode so software can reopen configuration
  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      config_done_flag_r         <= 1'b0;
      physical_gate_on_r         <= 1'b0;
      gate_output_select_r       <= 1'b0;
      loop_divider_value_r       <= `BPT_RST_BYTE;
      out1_phase_en_r            <= `BPT_RST_NIBBLE;
      out2_phase_en_r            <= `BPT_RST_NIBBLE;
      inter_phase_delay_r        <= 5'h00;
      phase_off_time_r           <= 3'h0;
      gate_phase_output_select_r <= 1'b0;
      internal_phase_route_r     <= `BPT_RST_ROUTE;
    end else if (wr_stb) begin
      if (addr == `BPT_ADDR_CONFIG_DONE) begin
        config_done_flag_r <= wdata[0];
      end else if (!config_done_flag_r) begin
        case (addr)
          `BPT_ADDR_GATE_EN:    physical_gate_on_r   <= wdata[0];
          `BPT_ADDR_GATE_OUT:   gate_output_select_r <= wdata[0];
          `BPT_ADDR_LOOP_DIV:   loop_divider_value_r <= wdata;
          `BPT_ADDR_OUT1_PH_EN: out1_phase_en_r <= wdata[`BPT_PH_EN_MSB:0];
          `BPT_ADDR_OUT2_PH_EN: out2_phase_en_r <= wdata[`BPT_PH_EN_MSB:0];
          `BPT_ADDR_OFF_DELAY: begin
            inter_phase_delay_r <= wdata[`BPT_DELAY_MSB:`BPT_DELAY_LSB];
            phase_off_time_r    <= wdata[`BPT_OFF_MSB:`BPT_OFF_LSB];
          end
          `BPT_ADDR_GATE_PHASE: gate_phase_output_select_r <= wdata[0];
          `BPT_ADDR_ROUTING:    internal_phase_route_r <= wdata[`BPT_ROUTE_MSB:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ********************************
  // loop clock divider
  // ********************************
  reg  [7:0] div_cnt_r;
  reg        tick_r;
  wire       run;

  assign run = config_done_flag_r;

  always @(posedge CORE_CLK) begin
    if (!RSTN || !run) begin
      div_cnt_r <= 8'h00;
      tick_r    <= 1'b0;
    end else if (div_cnt_r == loop_divider_value_r) begin
      div_cnt_r <= 8'h00;
      tick_r    <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
      tick_r    <= 1'b0;
    end
  end

  // ********************************
  // phase sequencers
  // ********************************
  // next enabled phase after cur, ascending with wrap; cur itself if alone
  function [1:0] next_phase;
    input [3:0] en;
    input [1:0] cur;
    reg   [1:0] k;
    reg         found;
    integer     j;
    begin
      next_phase = cur;
      found      = 1'b0;
      for (j = 1; j <= 4; j = j + 1) begin
        k = cur + j[1:0];
        if (!found && en[k]) begin
          next_phase = k;
          found      = 1'b1;
        end
      end
    end
  endfunction

  wire [2:0] off_eff;
  assign off_eff = (phase_off_time_r == 3'h0) ? `BPT_MIN_OFF : phase_off_time_r;

  genvar o;
  generate
    for (o = 0; o < 2; o = o + 1) begin : g_out
      wire [3:0] en;
      reg  [4:0] slot_cnt_r;
      reg  [1:0] cur_r;
      reg [11:0] off_cnt_r;
      reg  [3:0] started_r;
      reg  [3:0] ph_r;
      integer    i;

      assign en = (o == 0) ? out1_phase_en_r : out2_phase_en_r;
      assign ph_all[4*o +: 4] = ph_r;

      // each slot lasts the same delay, so the period is phases times delay
      always @(posedge CORE_CLK) begin
        if (!RSTN || !run) begin
          slot_cnt_r <= 5'h00;
          cur_r      <= next_phase(en, 2'h3);
          off_cnt_r  <= 12'h000;
          started_r  <= 4'h0;
          ph_r       <= 4'h0;
        end else begin
          for (i = 0; i < 4; i = i + 1) begin
            ph_r[i] <= en[i] & started_r[i] & (off_cnt_r[3*i +: 3] == 3'h0);
          end
          if (tick_r && (|en)) begin
            for (i = 0; i < 4; i = i + 1) begin
              if (off_cnt_r[3*i +: 3] != 3'h0) begin
                off_cnt_r[3*i +: 3] <= off_cnt_r[3*i +: 3] - 3'h1;
              end
            end
            if (slot_cnt_r == 5'h00) begin
              off_cnt_r[3*cur_r +: 3] <= off_eff;
              started_r[cur_r]        <= 1'b1;
              slot_cnt_r              <= inter_phase_delay_r;
              cur_r                   <= next_phase(en, cur_r);
            end else begin
              slot_cnt_r <= slot_cnt_r - 5'h01;
            end
          end
        end
      end
    end
  endgenerate

  // ********************************
  // outputs
  // ********************************
  // an illegal association setting keeps the gate quiet rather than guess a mapping
  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      PHYSICAL_GATE_ON <= 1'b0;
      OUT1_PHASES      <= 4'h0;
      OUT2_PHASES      <= 4'h0;
      OPERATION_MODE   <= 1'b0;
    end else begin
      PHYSICAL_GATE_ON <= run & physical_gate_on_r
                          & ~gate_output_select_r
                          & ~gate_phase_output_select_r
                          & ph_all[internal_phase_route_r];
      OUT1_PHASES      <= ph_all[3:0];
      OUT2_PHASES      <= ph_all[7:4];
      OPERATION_MODE   <= run;
    end
  end

endmodule
`default_nettype wire

// [testbench/bpt_config_top_props.sv]
`timescale 1ns/1ns
`default_nettype none
module bpt_config_props (
  // clock and reset
  input wire logic       CORE_CLK,
  input wire logic       RSTN,
  // watched pins
  input wire logic       CSB_N,
  input wire logic       SDO,
  input wire logic       PHYSICAL_GATE_ON,
  input wire logic [3:0] OUT1_PHASES,
  input wire logic [3:0] OUT2_PHASES,
  input wire logic       OPERATION_MODE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  // ******
  // properties
  // ******
  rst_clears_a:
    assert property ($rose(RSTN) |-> {SDO, PHYSICAL_GATE_ON, OUT1_PHASES, OUT2_PHASES,
      OPERATION_MODE} == 11'h000) else $error("outputs not cleared by reset");
  sdo_idle_a:
    assert property (CSB_N [*8] |-> !SDO) else $error("data out not quiet when idle");
  mode_by_frame_a:
    assert property ($changed(OPERATION_MODE) |-> !$past(CSB_N, 4)) else $error("mode moved");
  out1_held_a:
    assert property ($changed(OUT1_PHASES) |-> OPERATION_MODE || $past(OPERATION_MODE, 3))
      else $error("output 1 phases moved while configuring");
  out2_held_a:
    assert property ($changed(OUT2_PHASES) |-> OPERATION_MODE || $past(OPERATION_MODE, 3))
      else $error("output 2 phases moved while configuring");
  out1_one_fall_a:
    assert property ($past(OPERATION_MODE, 4) && OPERATION_MODE |->
      $onehot0($past(OUT1_PHASES, 4) & ~$past(OUT1_PHASES, 3))) else $error("two phases 1");
  out2_one_fall_a:
    assert property ($past(OPERATION_MODE, 4) && OPERATION_MODE |->
      $onehot0($past(OUT2_PHASES, 4) & ~$past(OUT2_PHASES, 3))) else $error("two phases 2");
  gate_locked_a:
    assert property (PHYSICAL_GATE_ON |-> OPERATION_MODE || $past(OPERATION_MODE, 3))
      else $error("gate on while configuring");
endmodule
bind bpt_config_top bpt_config_props bpt_config_props_i (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
  .CSB_N(CSB_N), .SDO(SDO), .PHYSICAL_GATE_ON(PHYSICAL_GATE_ON), .OUT1_PHASES(OUT1_PHASES),
  .OUT2_PHASES(OUT2_PHASES), .OPERATION_MODE(OPERATION_MODE));
`default_nettype wire

// [testbench/bpt_spi_host.sv]
`timescale 1ns/1ns
`default_nettype none
module bpt_spi_host (
  // clock
  input  wire logic CORE_CLK,
  // serial pins
  output var logic  SCLK,
  output var logic  CSB_N,
  output var logic  SDI,
  input  wire logic SDO
);
  initial begin
    SCLK = 1'b0;
    CSB_N = 1'b1;
    SDI = 1'b0;
  end
  // ******
  // frame engine
  // ******
  // six core cycles a half period stays clear of the pin synchronisers
  task automatic frame(input logic wr, input logic [6:0] adr, input logic [7:0] din,
                       output logic [7:0] dout);
    logic [15:0] sh;
    sh = {wr, adr, din};
    dout = 8'h00;
    @(posedge CORE_CLK);
    CSB_N <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      SDI <= sh[i];
      repeat (6) @(posedge CORE_CLK);
      SCLK <= 1'b1;
      if (i < 8)
        dout[i] = SDO;
      repeat (6) @(posedge CORE_CLK);
      SCLK <= 1'b0;
    end
    repeat (6) @(posedge CORE_CLK);
    CSB_N <= 1'b1;
    // a released line must not look like a held bit
    SDI <= ~sh[0];
    repeat (6) @(posedge CORE_CLK);
  endtask
endmodule
`default_nettype wire

// [testbench/tb_bpt_config_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "bpt_map.vh"
module tb_bpt_config_top;
  logic        CORE_CLK;
  logic        RSTN;
  logic        SCLK;
  logic        CSB_N;
  logic        SDI;
  logic        SDO;
  logic        PHYSICAL_GATE_ON;
  logic        OPERATION_MODE;
  logic [3:0]  OUT1_PHASES;
  logic [3:0]  OUT2_PHASES;
  int          err_total = 0;
  int          checks = 0;
  logic [6:0]  ra [8] = '{7'h01, 7'h02, 7'h09, 7'h0b, 7'h0c, 7'h0d, 7'h0f, 7'h10};
  logic [7:0]  rv [8] = '{8'h01, 8'h00, 8'ha5, 8'h0f, 8'h0a, 8'h5c, 8'h00, 8'h03};
  // divider, off/delay, out1 enables, out2 enables, route
  logic [39:0] cfg [3] = '{40'h02_1a0b_0201, 40'h00_f804_0602, 40'hff_0f0f_0f03};
  bpt_config_top bpt_config_top_i (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .SCLK(SCLK),
    .CSB_N(CSB_N), .SDI(SDI), .SDO(SDO), .PHYSICAL_GATE_ON(PHYSICAL_GATE_ON),
    .OUT1_PHASES(OUT1_PHASES), .OUT2_PHASES(OUT2_PHASES), .OPERATION_MODE(OPERATION_MODE));
  bpt_spi_host bpt_spi_host_i (.CORE_CLK(CORE_CLK), .SCLK(SCLK), .CSB_N(CSB_N), .SDI(SDI),
    .SDO(SDO));
  initial begin
    CORE_CLK = 1'b0;
    forever #50 CORE_CLK = ~CORE_CLK;
  end
  // ******
  // helpers
  // ******
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    bpt_spi_host_i.frame(1'b1, a, d, x);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] x;
    bpt_spi_host_i.frame(1'b0, a, 8'h00, x);
    check({8'h00, x}, {8'h00, e});
  endtask
  // 0..3 output 1 phases, 4 gate, 5..8 output 2 phases
  function automatic logic pick(input int s);
    return s == 4 ? PHYSICAL_GATE_ON : (s > 4 ? OUT2_PHASES[s - 5] : OUT1_PHASES[s]);
  endfunction
  task automatic wait_lvl(input int s, input logic v, inout int n);
    int g;
    g = 0;
    while (pick(s) !== v) begin
      @(negedge CORE_CLK);
      n++;
      g++;
      if (g > 5000) begin
        err_total++;
        wrap_up();
      end
    end
  endtask
  task automatic measure(input int s, input int lo, input int per);
    int n;
    n = 0;
    wait_lvl(s, 1'b1, n);
    wait_lvl(s, 1'b0, n);
    n = 0;
    wait_lvl(s, 1'b1, n);
    check(16'(n), 16'(lo));
    wait_lvl(s, 1'b0, n);
    check(16'(n), 16'(per));
  endtask
  // ******
  // sequence
  // ******
  initial begin
    logic [39:0] c;
    int          tk;
    int          lo;
    int          sl;
    int          n;
    RSTN = 1'b0;
    repeat (4) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    for (int k = 0; k < 8; k++) begin
      rdchk(ra[k], 8'h00);
      wr(ra[k], rv[k]);
      rdchk(ra[k], rv[k]);
    end
    wr(7'h05, 8'h77);
    rdchk(7'h05, 8'h00);
    for (int k = 0; k < 3; k++) begin
      c = cfg[k];
      wr(`BPT_ADDR_CONFIG_DONE, 8'h00);
      wr(`BPT_ADDR_LOOP_DIV, c[39:32]);
      wr(`BPT_ADDR_OFF_DELAY, c[31:24]);
      wr(`BPT_ADDR_OUT1_PH_EN, c[23:16]);
      wr(`BPT_ADDR_OUT2_PH_EN, c[15:8]);
      wr(`BPT_ADDR_ROUTING, c[7:0]);
      wr(`BPT_ADDR_GATE_EN, 8'h01);
      wr(`BPT_ADDR_CONFIG_DONE, 8'h01);
      tk = int'(c[39:32]) + 1;
      lo = (c[26:24] == 3'h0 ? 1 : int'(c[26:24])) * tk;
      sl = (int'(c[31:27]) + 1) * tk;
      measure(int'(c[1:0]), lo, $countones(c[23:16]) * sl);
      measure(4, lo, $countones(c[23:16]) * sl);
      measure(5 + int'(c[1:0]), lo, $countones(c[15:8]) * sl);
    end
    wr(`BPT_ADDR_OUT1_PH_EN, 8'h05);
    rdchk(`BPT_ADDR_OUT1_PH_EN, 8'h0f);
    check(16'(OPERATION_MODE), 16'h0001);
    wr(`BPT_ADDR_CONFIG_DONE, 8'h00);
    wr(`BPT_ADDR_OUT1_PH_EN, 8'h0e);
    rdchk(`BPT_ADDR_OUT1_PH_EN, 8'h0e);
    wr(`BPT_ADDR_LOOP_DIV, 8'h00);
    wr(`BPT_ADDR_GATE_EN, 8'h00);
    wr(`BPT_ADDR_CONFIG_DONE, 8'h01);
    // off time outlasts the output 1 phase period here, so every output 1 phase stays low
    rdchk(`BPT_ADDR_STATUS, 8'h80);
    // short off time so the routed phase is mostly high and a stuck gate would show
    wr(`BPT_ADDR_CONFIG_DONE, 8'h00);
    wr(`BPT_ADDR_OFF_DELAY, 8'h09);
    wr(`BPT_ADDR_CONFIG_DONE, 8'h01);
    n = 0;
    tk = 0;
    repeat (300) begin
      @(negedge CORE_CLK);
      if (PHYSICAL_GATE_ON !== 1'b0)
        n++;
      if (OUT1_PHASES[3] === 1'b1)
        tk++;
    end
    check(16'(n), 16'h0000);
    check(16'(tk > 200), 16'h0001);
    @(posedge CORE_CLK);
    RSTN <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    check(16'(OPERATION_MODE), 16'h0000);
    rdchk(`BPT_ADDR_OUT1_PH_EN, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
